/* File: logic/homing_pkg.sv */
package homing_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 7;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SPEED_W = 16;
  localparam int DIST_W = 32;
  localparam int TIME_W = 16;
  localparam int FILT_W = 8;
  localparam int METHOD_W = 4;
  localparam int DI_W = 8;
  localparam int BCD_W = 4;
  localparam int SLOW_W = 1 + DI_W + BCD_W + 1;
  localparam int FAST_W = 2;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_METHOD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_HSPEED = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CREEP = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_SHIFT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_HOMEPOS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_POSTDOG = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_POLARITY = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_FILTER = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_ACCEL = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_DECEL = 8'h2C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_POSITION = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_POSSEL = 8'h38;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_ERRCLR_BIT = 2;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_DOG_BIT = 3;
  localparam int STAT_STATE_LSB = 4;

  localparam logic [METHOD_W-1:0] METHOD_REAR = 4'h5;
  localparam logic [METHOD_W-1:0] METHOD_COUNT = 4'h6;
  localparam logic [METHOD_W-1:0] METHOD_CRADLE = 4'h7;

  localparam logic [SPEED_W-1:0] RST_HSPEED = 16'h0064;
  localparam logic [SPEED_W-1:0] RST_CREEP = 16'h000A;
  localparam logic [DIST_W-1:0] RST_DIST = 32'h0000_0000;
  localparam logic [FILT_W-1:0] RST_FILTER = 8'h04;
  localparam logic [TIME_W-1:0] RST_TIME = 16'h0001;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_FAST = 7'h02,
    ST_DECEL = 7'h04,
    ST_TRACK = 7'h08,
    ST_COUNT = 7'h10,
    ST_LATCH = 7'h20,
    ST_DONE = 7'h40
  } hom_state_t;

  typedef struct packed {
    logic [METHOD_W-1:0] method;
    logic direction;
    logic [SPEED_W-1:0] homingSpeed;
    logic [SPEED_W-1:0] creepSpeed;
    logic [DIST_W-1:0] shiftDist;
    logic [DIST_W-1:0] homePos;
    logic [DIST_W-1:0] postDist;
    logic dogPolarity;
    logic [FILT_W-1:0] filterTime;
    logic [TIME_W-1:0] accelTime;
    logic [TIME_W-1:0] decelTime;
    logic bcdSelect;
  } hom_cfg_t;

endpackage

/* File: logic/input_filter.sv */
`timescale 1ns/10ps
module input_filter import homing_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic [FILT_W-1:0] filterTime,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] filtered
);

  logic [WIDTH-1:0] sync1_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] sync3_ff;
  logic [WIDTH-1:0] filtered_ff;
  logic [FILT_W-1:0] holdCnt_ff;
  logic agree;

  assign agree = (sync2_ff == sync3_ff);
  assign filtered = filtered_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // one shared hold counter: any bit moving restarts the whole vector
  always_ff @(posedge clk) begin
    if (srst) begin
      holdCnt_ff <= '0;
      filtered_ff <= '0;
    end else if (!agree || sync3_ff == filtered_ff) begin
      holdCnt_ff <= '0;
    end else if (holdCnt_ff >= filterTime) begin
      filtered_ff <= sync3_ff; // R11
      holdCnt_ff <= '0;
    end else if (tick) begin
      holdCnt_ff <= holdCnt_ff + 1'b1;
    end
  end

endmodule

/* File: logic/homing_sequencer.sv */
// Notes on behaviour
// [R1] controller selects manual homing: auto/manual on, all point inputs low; in BCD mode the code checks the digit selects instead
// [R2] method value 5 runs dog type rear end reference homing
// [R3] method value 6 runs count type front end reference homing
// [R4] approach at homing speed until the dog is seen
// [R5] after the dog is seen, move at creep speed
// [R6] home is offset by the shift distance counted past dog rear end
// [R7] travel the post-dog distance after passing the dog rear end
// [R8] ramps use the acceleration and deceleration times of table entry one
// [R9] on completion current position loads the home position data
// [R10] with BCD selection the controller holds the four digit selects low
// [R11] external input changes count only after the input filter time
// [R12] controller changes selection early enough to cover filter and skew
// [R13] count type: decelerate at dog front, home after post plus shift
// [R14] rear end and count types never use the Z-phase pulse
// [R15] dog cradle: home is first Z-phase pulse after dog front end
// [R16] dog input is read according to the dog polarity setting
// [R17] homing motion follows the homing direction setting
// [R18] rear end: decelerate at front, home post plus shift beyond rear
// [R19] sequencer is a state machine: idle, fast, decel, track, count,
//       latch, complete
`timescale 1ns/10ps
module homing_sequencer import homing_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  input wire logic autoManualSelect,
  input wire logic [DI_W-1:0] pointTableSelectInputs,
  input wire logic [BCD_W-1:0] bcdDigitSelectInputs,
  input wire logic proximityDog,
  input wire logic axisPulse,
  input wire logic zPhase,
  output logic [SPEED_W-1:0] speedCommand,
  output logic moveDir,
  output logic homingBusy,
  output logic homingDone,
  output logic [DIST_W-1:0] currentPosition
);

  hom_cfg_t cfg_ff;
  hom_state_t state_ff;
  hom_state_t nxt_state;
  logic [TICK_CNT_W-1:0] tickCnt_ff;
  logic usTick_ff;
  logic startReq_ff;
  logic abortReq_ff;
  logic error_ff;
  logic [SLOW_W-1:0] slowFilt;
  logic [FAST_W-1:0] fastFilt;
  logic dogPrev_ff;
  logic pulsePrev_ff;
  logic zPrev_ff;
  logic dogActive;
  logic dogFront;
  logic dogRear;
  logic axisStep;
  logic zRise;
  logic modeSel;
  logic methodOk;
  logic startOk;
  logic [DIST_W-1:0] distCnt_ff;
  logic [DIST_W-1:0] distTarget;
  logic distReached;
  logic counting;
  logic [SPEED_W-1:0] speed_ff;
  logic [SPEED_W-1:0] speedTarget;
  logic [TIME_W-1:0] rampCnt_ff;
  logic moveDir_ff;
  logic [DIST_W-1:0] position_ff;
  logic busy_ff;
  logic done_ff;
  logic [DATA_W-1:0] rdData_ff;
  logic [DATA_W-1:0] statusWord;

  function automatic logic [DIST_W-1:0] stepPos(
    input logic [DIST_W-1:0] pos,
    input logic dir
  );
    return dir ? pos + 1'b1 : pos - 1'b1;
  endfunction

  assign regRdData = rdData_ff;
  assign speedCommand = speed_ff;
  assign moveDir = moveDir_ff;
  assign homingBusy = busy_ff;
  assign homingDone = done_ff;
  assign currentPosition = position_ff;

  // microsecond tick paces both the slow input filter and the speed ramp
  always_ff @(posedge clk) begin
    if (srst) begin
      tickCnt_ff <= '0;
      usTick_ff <= 1'b0;
    end else if (tickCnt_ff == TICK_LAST) begin
      tickCnt_ff <= '0;
      usTick_ff <= 1'b1;
    end else begin
      tickCnt_ff <= tickCnt_ff + 1'b1;
      usTick_ff <= 1'b0;
    end
  end

  input_filter #(.WIDTH(SLOW_W)) slowFilter (
    .clk(clk),
    .srst(srst),
    .tick(usTick_ff),
    .filterTime(cfg_ff.filterTime),
    .rawIn({autoManualSelect, pointTableSelectInputs,
            bcdDigitSelectInputs, proximityDog}),
    .filtered(slowFilt)
  ); // R11

  // encoder lines must not lose pulses, so they get no hold time
  input_filter #(.WIDTH(FAST_W)) fastFilter (
    .clk(clk),
    .srst(srst),
    .tick(1'b1),
    .filterTime('0),
    .rawIn({axisPulse, zPhase}),
    .filtered(fastFilt)
  );

  assign dogActive = (slowFilt[0] == cfg_ff.dogPolarity); // R16
  assign dogFront = dogActive & ~dogPrev_ff;
  assign dogRear = ~dogActive & dogPrev_ff;
  assign axisStep = fastFilt[1] & ~pulsePrev_ff;
  assign zRise = fastFilt[0] & ~zPrev_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      dogPrev_ff <= 1'b0;
      pulsePrev_ff <= 1'b0;
      zPrev_ff <= 1'b0;
    end else begin
      dogPrev_ff <= dogActive;
      pulsePrev_ff <= fastFilt[1];
      zPrev_ff <= fastFilt[0];
    end
  end

  // point-table mode checks the eight selects, BCD mode the digit selects
  always_comb begin
    if (cfg_ff.bcdSelect) begin
      modeSel = slowFilt[SLOW_W-1] & ~|slowFilt[BCD_W:1]; // R10
    end else begin
      modeSel = slowFilt[SLOW_W-1] & ~|slowFilt[SLOW_W-2:BCD_W+1]; // R1
    end
  end

  assign methodOk = (cfg_ff.method == METHOD_REAR) ||
                    (cfg_ff.method == METHOD_COUNT) ||
                    (cfg_ff.method == METHOD_CRADLE);
  assign startOk = startReq_ff & modeSel & methodOk;

  assign distTarget = cfg_ff.postDist + cfg_ff.shiftDist; // R6 R7 R13 R18
  assign distReached = (distCnt_ff >= distTarget);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (startOk) begin
          nxt_state = ST_FAST;
        end
      end
      ST_FAST: begin
        if (dogFront) begin
          nxt_state = ST_DECEL; // R4 R13 R18
        end
      end
      ST_DECEL: begin
        if (cfg_ff.method == METHOD_COUNT) begin
          if (distReached) begin
            nxt_state = ST_LATCH; // R3 R13
          end else if (speed_ff == speedTarget) begin
            nxt_state = ST_COUNT;
          end
        end else if (cfg_ff.method == METHOD_REAR) begin
          if (dogRear) begin
            nxt_state = ST_COUNT; // R2 R18
          end else if (speed_ff == speedTarget) begin
            nxt_state = ST_TRACK;
          end
        end else if (zRise) begin
          nxt_state = ST_LATCH; // R15
        end else if (speed_ff == speedTarget) begin
          nxt_state = ST_TRACK;
        end
      end
      ST_TRACK: begin
        // Z-phase is looked at only for the cradle method
        if (cfg_ff.method == METHOD_REAR && dogRear) begin
          nxt_state = ST_COUNT; // R14 R18
        end else if (cfg_ff.method == METHOD_CRADLE && zRise) begin
          nxt_state = ST_LATCH; // R15
        end
      end
      ST_COUNT: begin
        if (distReached) begin
          nxt_state = ST_LATCH; // R6 R7
        end
      end
      ST_LATCH: begin
        nxt_state = ST_DONE;
      end
      ST_DONE: begin
        if (startOk) begin
          nxt_state = ST_FAST;
        end else if (!modeSel) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    // leaving manual mode or abort stops any motion at once
    if (abortReq_ff || (!modeSel && state_ff != ST_IDLE)) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state; // R19
    end
  end

  // count type counts from the front end, rear end type from the rear end
  assign counting = (state_ff == ST_COUNT) ||
                    (state_ff == ST_DECEL && cfg_ff.method == METHOD_COUNT);

  always_ff @(posedge clk) begin
    if (srst) begin
      distCnt_ff <= '0;
    end else if (!counting) begin
      distCnt_ff <= '0;
    end else if (axisStep) begin
      distCnt_ff <= distCnt_ff + 1'b1; // R7 R13
    end
  end

  always_comb begin
    unique case (state_ff)
      ST_FAST: speedTarget = cfg_ff.homingSpeed; // R4
      ST_DECEL, ST_TRACK, ST_COUNT: speedTarget = cfg_ff.creepSpeed; // R5
      default: speedTarget = '0;
    endcase
  end

  // stopping states drop the command at once; creep is slow enough
  always_ff @(posedge clk) begin
    if (srst) begin
      speed_ff <= '0;
      rampCnt_ff <= '0;
    end else if (speedTarget == '0 && state_ff != ST_FAST) begin
      speed_ff <= '0;
      rampCnt_ff <= '0;
    end else if (speed_ff == speedTarget) begin
      rampCnt_ff <= '0;
    end else if (speed_ff < speedTarget) begin
      if (rampCnt_ff >= cfg_ff.accelTime) begin
        speed_ff <= speed_ff + 1'b1; // R8
        rampCnt_ff <= '0;
      end else if (usTick_ff) begin
        rampCnt_ff <= rampCnt_ff + 1'b1;
      end
    end else begin
      if (rampCnt_ff >= cfg_ff.decelTime) begin
        speed_ff <= speed_ff - 1'b1; // R8
        rampCnt_ff <= '0;
      end else if (usTick_ff) begin
        rampCnt_ff <= rampCnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      moveDir_ff <= 1'b0;
    end else if (startOk) begin
      moveDir_ff <= cfg_ff.direction; // R17
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      position_ff <= '0;
    end else if (state_ff == ST_LATCH) begin
      position_ff <= cfg_ff.homePos; // R9
    end else if (axisStep) begin
      position_ff <= stepPos(position_ff, moveDir_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_DONE);
      done_ff <= (nxt_state == ST_DONE);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      startReq_ff <= 1'b0;
      abortReq_ff <= 1'b0;
    end else begin
      startReq_ff <= regWr && regAddr == ADDR_CTRL &&
                     regWrData[CTRL_START_BIT];
      abortReq_ff <= regWr && regAddr == ADDR_CTRL &&
                     regWrData[CTRL_ABORT_BIT];
    end
  end

  // rejected start is sticky; a new rejection beats a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      error_ff <= 1'b0;
    end else if (startReq_ff && !startOk &&
                 (state_ff == ST_IDLE || state_ff == ST_DONE)) begin
      error_ff <= 1'b1;
    end else if (regWr && regAddr == ADDR_CTRL &&
                 regWrData[CTRL_ERRCLR_BIT]) begin
      error_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_ff.method <= METHOD_REAR;
      cfg_ff.direction <= 1'b0;
      cfg_ff.homingSpeed <= RST_HSPEED;
      cfg_ff.creepSpeed <= RST_CREEP;
      cfg_ff.shiftDist <= RST_DIST;
      cfg_ff.homePos <= RST_DIST;
      cfg_ff.postDist <= RST_DIST;
      cfg_ff.dogPolarity <= 1'b1;
      cfg_ff.filterTime <= RST_FILTER;
      cfg_ff.accelTime <= RST_TIME;
      cfg_ff.decelTime <= RST_TIME;
      cfg_ff.bcdSelect <= 1'b0;
    end else if (regWr) begin
      unique case (regAddr)
        ADDR_METHOD: cfg_ff.method <= regWrData[METHOD_W-1:0];
        ADDR_DIR: cfg_ff.direction <= regWrData[0];
        ADDR_HSPEED: cfg_ff.homingSpeed <= regWrData[SPEED_W-1:0];
        ADDR_CREEP: cfg_ff.creepSpeed <= regWrData[SPEED_W-1:0];
        ADDR_SHIFT: cfg_ff.shiftDist <= regWrData;
        ADDR_HOMEPOS: cfg_ff.homePos <= regWrData;
        ADDR_POSTDOG: cfg_ff.postDist <= regWrData;
        ADDR_POLARITY: cfg_ff.dogPolarity <= regWrData[0];
        ADDR_FILTER: cfg_ff.filterTime <= regWrData[FILT_W-1:0];
        ADDR_ACCEL: cfg_ff.accelTime <= regWrData[TIME_W-1:0];
        ADDR_DECEL: cfg_ff.decelTime <= regWrData[TIME_W-1:0];
        ADDR_POSSEL: cfg_ff.bcdSelect <= regWrData[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[STAT_BUSY_BIT] = busy_ff;
    statusWord[STAT_DONE_BIT] = done_ff;
    statusWord[STAT_ERR_BIT] = error_ff;
    statusWord[STAT_DOG_BIT] = dogActive;
    statusWord[STAT_STATE_LSB +: $bits(hom_state_t)] = state_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_ff <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_METHOD: rdData_ff <= DATA_W'(cfg_ff.method);
        ADDR_DIR: rdData_ff <= DATA_W'(cfg_ff.direction);
        ADDR_HSPEED: rdData_ff <= DATA_W'(cfg_ff.homingSpeed);
        ADDR_CREEP: rdData_ff <= DATA_W'(cfg_ff.creepSpeed);
        ADDR_SHIFT: rdData_ff <= cfg_ff.shiftDist;
        ADDR_HOMEPOS: rdData_ff <= cfg_ff.homePos;
        ADDR_POSTDOG: rdData_ff <= cfg_ff.postDist;
        ADDR_POLARITY: rdData_ff <= DATA_W'(cfg_ff.dogPolarity);
        ADDR_FILTER: rdData_ff <= DATA_W'(cfg_ff.filterTime);
        ADDR_ACCEL: rdData_ff <= DATA_W'(cfg_ff.accelTime);
        ADDR_DECEL: rdData_ff <= DATA_W'(cfg_ff.decelTime);
        ADDR_STATUS: rdData_ff <= statusWord;
        ADDR_POSITION: rdData_ff <= position_ff;
        ADDR_POSSEL: rdData_ff <= DATA_W'(cfg_ff.bcdSelect);
        default: rdData_ff <= '0;
      endcase
    end else begin
      rdData_ff <= '0;
    end
  end

endmodule

/* File: testbench/homing_monitor.sv */
`timescale 1ns/10ps
module homing_monitor import homing_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic [SPEED_W-1:0] speedCommand,
  input wire logic moveDir,
  input wire logic homingBusy,
  input wire logic homingDone,
  input wire logic [DIST_W-1:0] currentPosition
);
  logic dirSh_ff;
  logic [SPEED_W-1:0] hspSh_ff;
  logic [DIST_W-1:0] homeSh_ff;
  logic startWr;
  assign startWr = regWr && regAddr == ADDR_CTRL && regWrData[CTRL_START_BIT];
  // shadow copies from bus writes, since the checker sees ports only
  always_ff @(posedge clk) begin
    if (srst) begin
      dirSh_ff <= 1'b0;
      hspSh_ff <= RST_HSPEED;
      homeSh_ff <= RST_DIST;
    end else if (regWr) begin
      if (regAddr == ADDR_DIR) dirSh_ff <= regWrData[0];
      if (regAddr == ADDR_HSPEED) hspSh_ff <= regWrData[SPEED_W-1:0];
      if (regAddr == ADDR_HOMEPOS) homeSh_ff <= regWrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence settled;
    !homingBusy ##1 !homingBusy;
  endsequence
  sequence busyRise;
    !homingBusy ##1 homingBusy;
  endsequence
  a_rd_quiet: assert property (!$past(regRd) |-> regRdData == '0)
    else $error("read data outside its slot");
  // start strobe edge, then state and busy flop load together one edge later
  a_start_busy: assert property (busyRise |-> $past(startWr, 2))
    else $error("busy rose without a start two cycles earlier");
  a_busy_done: assert property (!(homingBusy && homingDone))
    else $error("busy and done high together");
  a_idle_still: assert property (settled |-> speedCommand == '0)
    else $error("speed commanded while not homing");
  a_speed_cap: assert property (homingBusy |-> speedCommand <= hspSh_ff)
    else $error("speed above homing speed");
  a_speed_ramp: assert property (speedCommand == '0 ||
    speedCommand == $past(speedCommand) ||
    speedCommand == $past(speedCommand) + 16'h1 ||
    speedCommand == $past(speedCommand) - 16'h1)
    else $error("speed jumped by more than one unit");
  a_dir_follow: assert property (homingBusy |-> moveDir == dirSh_ff)
    else $error("motion against the homing direction");
  a_done_pos: assert property ($rose(homingDone) |->
    currentPosition == homeSh_ff)
    else $error("position not loaded with home data at completion");
endmodule

/* File: testbench/axis_model.sv */
`timescale 1ns/10ps
module axis_model import homing_pkg::*; #(
  parameter int DOG_LO = 200,
  parameter int DOG_HI = 300,
  parameter int Z_MOD = 256
) (
  input wire logic clk,
  input wire logic rewind,
  input wire logic [SPEED_W-1:0] speedCommand,
  input wire logic moveDir,
  input wire logic homeDir,
  input wire logic dogPol,
  output logic axisPulse,
  output logic proximityDog,
  output logic zPhase,
  output int trav
);
  logic [2:0] ph_ff;
  // one unit per 8 clocks at any speed; a stopped shaft holds its level
  always_ff @(posedge clk) begin
    if (rewind) begin
      ph_ff <= 3'h0;
      trav <= 0;
    end else if (speedCommand != '0) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h3) trav <= (moveDir == homeDir) ? trav + 1 : trav - 1;
    end
  end
  assign axisPulse = ph_ff[2];
  assign proximityDog = dogPol ~^ (trav >= DOG_LO && trav <= DOG_HI);
  // single index mark, past the dog front and before the rear
  assign zPhase = trav == Z_MOD;
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench import homing_pkg::*;;
  localparam int LO = 200;
  localparam int HI = 300;
  localparam int ZM = 256;
  localparam int PD = 5;
  localparam int SH = 3;
  localparam logic [DATA_W-1:0] HP = 32'h0000_1234;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic autoManualSelect = 1'b1;
  logic [DI_W-1:0] pointTableSelectInputs = '0;
  logic [BCD_W-1:0] bcdDigitSelectInputs = '0;
  logic proximityDog, axisPulse, zPhase, moveDir, homingBusy, homingDone;
  logic [SPEED_W-1:0] speedCommand, spPrev = '0, maxSpd, lastSpd;
  logic [DIST_W-1:0] currentPosition;
  logic homeDir = 1'b1;
  logic dogPol = 1'b1;
  logic rewind = 1'b1;
  logic upPrev = 1'b0;
  int trav, n_mismatch = 0, n_compared = 0, cycles = 0;
  int lastChg = 0, gapUp, gapDn;
  logic [ADDR_W-1:0] rA [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  logic [DATA_W-1:0] rE [16] = '{32'h0, 32'h5, 32'h0, 32'h64, 32'hA, 32'h0,
    32'h0, 32'h0, 32'h1, 32'h4, 32'h1, 32'h1, 32'h10, 32'h0, 32'h0, 32'h0};
  logic [3:0] rM [4] = '{4'h5, 4'h6, 4'h7, 4'h5};
  logic rDir [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic rPol [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  int rExp [4] = '{HI + 1 + PD + SH, LO + PD + SH, ZM, HI + 1 + PD + SH};

  homing_sequencer homing_sequencer_i (.clk, .srst, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .autoManualSelect, .pointTableSelectInputs,
    .bcdDigitSelectInputs, .proximityDog, .axisPulse, .zPhase,
    .speedCommand, .moveDir, .homingBusy, .homingDone, .currentPosition);
  axis_model axis_model_i (.clk, .rewind, .speedCommand, .moveDir,
    .homeDir, .dogPol, .axisPulse, .proximityDog, .zPhase, .trav);

  always #5 clk = ~clk;

  // ramp gaps only between two steps in the same direction
  always @(posedge clk) begin
    cycles++;
    if (speedCommand != spPrev && speedCommand != '0) begin
      if (speedCommand > spPrev && upPrev) gapUp = cycles - lastChg;
      if (speedCommand < spPrev && !upPrev) gapDn = cycles - lastChg;
      upPrev = speedCommand > spPrev;
      lastChg = cycles;
    end
    if (speedCommand > maxSpd) maxSpd = speedCommand;
    if (speedCommand != '0) lastSpd = speedCommand;
    spPrev = speedCommand;
    if (cycles == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge clk);
  endtask

  initial begin
    logic [31:0] v;
    int k;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rewind <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rd(rA[i], v);
      chk(v, rE[i]);
    end
    wr(ADDR_FILTER, 32'h0);
    wr(ADDR_ACCEL, 32'h2);
    wr(ADDR_DECEL, 32'h1);
    wr(ADDR_HSPEED, 32'h4);
    wr(ADDR_CREEP, 32'h2);
    wr(ADDR_SHIFT, SH);
    wr(ADDR_POSTDOG, PD);
    wr(ADDR_HOMEPOS, HP);
    // three refused mode selections, then one taken in digit mode
    for (int i = 0; i < 4; i++) begin
      autoManualSelect <= (i != 0);
      pointTableSelectInputs <= (i == 1) ? 8'h01 : (i == 3) ? 8'h80 : 8'h00;
      bcdDigitSelectInputs <= (i == 2) ? 4'h1 : 4'h0;
      wr(ADDR_POSSEL, {31'h0, i > 1});
      repeat (10) @(posedge clk);
      wr(ADDR_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      rd(ADDR_STATUS, v);
      chk({30'h0, v[STAT_ERR_BIT], v[0]}, (i == 3) ? 32'h1 : 32'h2);
      wr(ADDR_CTRL, 32'h6);
    end
    pointTableSelectInputs <= '0;
    wr(ADDR_POSSEL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DIR, {31'h0, rDir[i]});
      wr(ADDR_POLARITY, {31'h0, rPol[i]});
      homeDir <= rDir[i];
      dogPol <= rPol[i];
      rewind <= 1'b1;
      @(posedge clk);
      rewind <= 1'b0;
      repeat (10) @(posedge clk);
      maxSpd = '0;
      gapUp = 0;
      gapDn = 0;
      wr(ADDR_METHOD, {28'h0, rM[i]});
      wr(ADDR_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      k = 0;
      while (homingDone !== 1'b1 && k < 20000) begin
        @(posedge clk);
        k++;
      end
      repeat (10) @(posedge clk);
      chk({31'h0, trav >= rExp[i] - 1 && trav <= rExp[i] + 1}, 32'h1);
      chk({31'h0, trav >= rExp[i] - 1 && trav <= rExp[i] + 1}, 32'h1);
      chk({31'h0, trav > 0}, 32'h1);
      chk({16'h0, maxSpd}, 32'h4);
      chk(gapUp, 32'd200);
      if (rM[i] != 4'h6) chk({16'h0, lastSpd}, 32'h2);
      if (rM[i] != 4'h6) chk(gapDn, 32'd100);
      chk(currentPosition, HP);
      rd(ADDR_POSITION, v);
      chk(v, HP);
      rd(ADDR_STATUS, v);
      chk(v & 32'hFFFF_FFF7, 32'h402);
    end
    wrap_up();
  end
endmodule

bind homing_sequencer homing_monitor homing_monitor_i (.clk, .srst,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .speedCommand,
  .moveDir, .homingBusy, .homingDone, .currentPosition);
